/* File: urt_pkg.sv */
package urt_pkg;
    // Register byte offsets
    localparam logic [7:0] CMD_OFS = 8'h00;
    localparam logic [7:0] IEN_OFS = 8'h04;
    localparam logic [7:0] IDIS_OFS = 8'h08;
    localparam logic [7:0] IMASK_OFS = 8'h0C;
    localparam logic [7:0] STAT_OFS = 8'h10;
    localparam logic [7:0] IDLE_OFS = 8'h14;
    localparam logic [7:0] BAUD_OFS = 8'h18;
    localparam logic [7:0] GUARD_OFS = 8'h1C;
    localparam logic [7:0] RXDATA_OFS = 8'h20;
    // Command bits
    localparam int CMD_START_WAIT_BIT = 0;
    localparam int CMD_CLR_STAT_BIT = 1;
    // Status and enable bit positions
    localparam int RXFULL_BIT = 0;
    localparam int TXFREE_BIT = 1;
    localparam int BRK_BIT = 2;
    localparam int OVR_BIT = 5;
    localparam int FRAME_BIT = 6;
    localparam int PAR_BIT = 7;
    localparam int TIMEOUT_BIT = 8;
    localparam int TXIDLE_BIT = 9;
    localparam int STAT_W = 10;
    // Reset values
    localparam logic [15:0] IDLE_RST = 16'h0000;
    localparam logic [15:0] BAUD_RST = 16'h0000;
    localparam logic [7:0] GUARD_RST = 8'h00;
    localparam logic [STAT_W-1:0] MASK_RST = 10'h000;
    // Longest timeguard: 212.50 ms at 833 us bit time, i.e. 255 bit periods
    localparam int TG_MAX_US_SLOW = 212500;
    localparam int BIT_US_SLOW = 833;
    localparam int TG_MAX_BITS = TG_MAX_US_SLOW / BIT_US_SLOW;
    localparam int GUARD_W = $clog2(TG_MAX_BITS + 1);

    typedef struct packed {
        logic parity_fault;
        logic frame_fault;
        logic [7:0] data;
    } urt_rx_char_t;

    typedef enum logic [1:0] {
        TO_OFF = 2'b00,
        TO_RUN = 2'b01,
        TO_EXPIRED = 2'b11,
        TO_WAIT = 2'b10
    } urt_to_state_t;
endpackage

/* File: urt_receiver_timeout.sv */
// Decided for this implementation: register access over APB and the register offsets.
`timescale 1ns/1ps
// Functional notes
// - Watch line idle; timeout flag marks frame end
// - Zero reload disables timeout, flag stays zero
// - Nonzero reload loads 16-bit down-counter
// - Counter decrements once per bit period
// - Each character taken into the receive buffer reloads the counter; one refused while the buffer is full does not
// - Counter reaching zero sets timeout flag
// - Start-wait command halts counter until next character
// - Timeguard up to baud-dependent maximum supported
// - Enable bits: tx idle 9, timeout 8
// - Enable bits: parity 7, frame 6, overrun 5
// - Enable bits: break 2, tx free 1, rx full 0

module urt_fifo #(
    parameter int WIDTH = 10,
    parameter int DEPTH = 4
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    // Fill side
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    // Drain side
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] DEPTH_C = (AW+1)'(DEPTH);
    localparam logic [AW-1:0] LAST_C = (AW)'(DEPTH - 1);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] cnt_q;
    logic [AW:0] cnt_d;
    logic nfull_q;
    wire push = in_valid_i & nfull_q;
    wire pop = out_valid_o & out_ready_i;

    assign out_valid_o = (cnt_q != '0);
    assign out_data_o = mem_q[rd_q];
    assign in_ready_o = nfull_q;
    assign cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
            nfull_q <= 1'b1;
        end else begin
            cnt_q <= cnt_d;
            nfull_q <= (cnt_d != DEPTH_C);
            if (push) begin
                wr_q <= (wr_q == LAST_C) ? '0 : wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= (rd_q == LAST_C) ? '0 : rd_q + 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (push) begin
            mem_q[wr_q] <= in_data_i;
        end
    end
endmodule

module urt_receiver_timeout
    import urt_pkg::*;
#(
    parameter int FIFO_DEPTH = 4
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // APB slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // Received characters from the line receiver
    input wire logic rx_valid_i,
    input wire urt_rx_char_t rx_char_i,
    output logic rx_ready_o,
    input wire logic break_detected_i,
    // Transmitter status
    input wire logic tx_holding_free_i,
    input wire logic tx_shift_idle_i,
    input wire logic tx_char_done_i,
    output logic tx_guard_busy_o,
    // Bit-period tick and interrupt
    output logic bit_tick_o,
    output logic irq_o
);
    // Bus decode
    wire acc = psel_i & penable_i & ~pready_o;
    wire wr_en = psel_i & penable_i & pready_o & pwrite_i;
    wire hit_cmd = (paddr_i == CMD_OFS);
    wire hit_ien = (paddr_i == IEN_OFS);
    wire hit_idis = (paddr_i == IDIS_OFS);
    wire hit_imask = (paddr_i == IMASK_OFS);
    wire hit_stat = (paddr_i == STAT_OFS);
    wire hit_idle = (paddr_i == IDLE_OFS);
    wire hit_baud = (paddr_i == BAUD_OFS);
    wire hit_guard = (paddr_i == GUARD_OFS);
    wire hit_rxd = (paddr_i == RXDATA_OFS);
    wire mapped = hit_cmd | hit_ien | hit_idis | hit_imask | hit_stat | hit_idle | hit_baud | hit_guard | hit_rxd;

    logic [15:0] idle_reload_value_q;
    logic [15:0] baud_div_q;
    logic [GUARD_W-1:0] guard_len_q;
    logic [STAT_W-1:0] mask_q;
    logic [15:0] div_cnt_q;
    logic [15:0] to_cnt_q;
    logic [GUARD_W-1:0] guard_cnt_q;
    urt_to_state_t to_state_q;
    logic timeout_q;
    logic brk_q;
    logic ovr_q;
    logic frame_q;
    logic par_q;

    // Receive buffer
    logic fifo_valid;
    logic fifo_ready;
    urt_rx_char_t fifo_char;
    wire rx_take = rx_valid_i & fifo_ready;
    wire rd_pop = wr_en ? 1'b0 : (psel_i & penable_i & pready_o & ~pwrite_i & hit_rxd);

    urt_fifo #(
        .WIDTH($bits(urt_rx_char_t)),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .in_valid_i(rx_valid_i),
        .in_ready_o(fifo_ready),
        .in_data_i(rx_char_i),
        .out_valid_o(fifo_valid),
        .out_ready_i(rd_pop),
        .out_data_o(fifo_char)
    );

    // Commands and status clear
    wire cmd_wr = wr_en & hit_cmd;
    wire start_wait = cmd_wr & pwdata_i[CMD_START_WAIT_BIT];
    wire clr_stat = cmd_wr & pwdata_i[CMD_CLR_STAT_BIT];
    wire reload_zero = (idle_reload_value_q == '0);

    // Bit-period divider
    wire bit_tick = (div_cnt_q == '0);

    // Timeout counter
    wire to_expire = bit_tick & (to_state_q == TO_RUN) & (to_cnt_q == 16'h0001);

    wire [STAT_W-1:0] status = {tx_shift_idle_i, timeout_q, par_q, frame_q, ovr_q, 2'b00,
                                brk_q, tx_holding_free_i, fifo_valid};

    logic [31:0] rd_data;
    always_comb begin
        rd_data = '0;
        if (hit_imask) begin
            rd_data[STAT_W-1:0] = mask_q;
        end else if (hit_stat) begin
            rd_data[STAT_W-1:0] = status;
        end else if (hit_idle) begin
            rd_data[15:0] = idle_reload_value_q;
        end else if (hit_baud) begin
            rd_data[15:0] = baud_div_q;
        end else if (hit_guard) begin
            rd_data[GUARD_W-1:0] = guard_len_q;
        end else if (hit_rxd) begin
            rd_data[$bits(urt_rx_char_t)-1:0] = fifo_char;
        end
    end

    // APB answer: one wait cycle, then pready with data
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o <= '0;
        end else begin
            pready_o <= acc;
            pslverr_o <= acc & ~mapped;
            prdata_o <= (acc & ~pwrite_i) ? rd_data : '0;
        end
    end

    // Configuration registers
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            idle_reload_value_q <= IDLE_RST;
            baud_div_q <= BAUD_RST;
            guard_len_q <= GUARD_RST[GUARD_W-1:0];
            mask_q <= MASK_RST;
        end else begin
            if (wr_en & hit_idle) begin
                idle_reload_value_q <= pwdata_i[15:0];
            end
            if (wr_en & hit_baud) begin
                baud_div_q <= pwdata_i[15:0];
            end
            if (wr_en & hit_guard) begin
                guard_len_q <= pwdata_i[GUARD_W-1:0];
            end
            if (wr_en & hit_ien) begin
                mask_q <= mask_q | (pwdata_i[STAT_W-1:0] & ~10'h018);
            end else if (wr_en & hit_idis) begin
                mask_q <= mask_q & ~pwdata_i[STAT_W-1:0];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            div_cnt_q <= BAUD_RST;
            bit_tick_o <= 1'b0;
        end else begin
            div_cnt_q <= bit_tick ? baud_div_q : div_cnt_q - 16'h0001;
            bit_tick_o <= bit_tick;
        end
    end

    // Timeout state machine
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            to_state_q <= TO_OFF;
            to_cnt_q <= '0;
        end else if (reload_zero) begin
            to_state_q <= TO_OFF;
            to_cnt_q <= '0;
        end else if (rx_take) begin
            to_state_q <= TO_RUN;
            to_cnt_q <= idle_reload_value_q;
        end else if (start_wait) begin
            to_state_q <= TO_WAIT;
        end else begin
            case (to_state_q)
                TO_OFF: begin
                    to_state_q <= TO_RUN;
                    to_cnt_q <= idle_reload_value_q;
                end
                TO_RUN: begin
                    if (bit_tick) begin
                        to_cnt_q <= to_cnt_q - 16'h0001;
                    end
                    if (to_expire) begin
                        to_state_q <= TO_EXPIRED;
                    end
                end
                TO_EXPIRED: to_state_q <= TO_EXPIRED;
                TO_WAIT: to_state_q <= TO_WAIT;
                default: to_state_q <= TO_OFF;
            endcase
        end
    end

    // Sticky status flags; a new event wins over a clear
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            timeout_q <= 1'b0;
            brk_q <= 1'b0;
            ovr_q <= 1'b0;
            frame_q <= 1'b0;
            par_q <= 1'b0;
        end else begin
            if (reload_zero) begin
                timeout_q <= 1'b0;
            end else if (to_expire) begin
                timeout_q <= 1'b1;
            end else if (clr_stat | start_wait) begin
                timeout_q <= 1'b0;
            end
            brk_q <= break_detected_i | (brk_q & ~clr_stat);
            ovr_q <= (rx_valid_i & ~fifo_ready) | (ovr_q & ~clr_stat);
            frame_q <= (rx_take & rx_char_i.frame_fault) | (frame_q & ~clr_stat);
            par_q <= (rx_take & rx_char_i.parity_fault) | (par_q & ~clr_stat);
        end
    end

    // Transmit timeguard, counted in bit periods
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            guard_cnt_q <= '0;
            tx_guard_busy_o <= 1'b0;
        end else begin
            if (tx_char_done_i) begin
                guard_cnt_q <= guard_len_q;
            end else if (bit_tick & (guard_cnt_q != '0)) begin
                guard_cnt_q <= guard_cnt_q - 1'b1;
            end
            tx_guard_busy_o <= tx_char_done_i ? (guard_len_q != '0) : (guard_cnt_q > 1) | (guard_cnt_q == 1 & ~bit_tick);
        end
    end

    // Outputs
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            irq_o <= 1'b0;
            rx_ready_o <= 1'b0;
        end else begin
            irq_o <= |(status & mask_q);
            rx_ready_o <= fifo_ready;
        end
    end
endmodule

/* File: urt_receiver_timeout_asserts.sv */
`timescale 1ns/1ps
module urt_receiver_timeout_asserts
    import urt_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // APB
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    // Transmitter, tick and interrupt
    input wire logic tx_holding_free_i,
    input wire logic tx_shift_idle_i,
    input wire logic tx_char_done_i,
    input wire logic tx_guard_busy_o,
    input wire logic bit_tick_o,
    input wire logic irq_o
);
    logic [STAT_W-1:0] mask_q;
    logic [15:0] idle_q;
    logic [15:0] baud_q;
    logic [7:0] guard_q;
    wire wr = psel_i && penable_i && pwrite_i && pready_o;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    sequence s_rd(a);
        pready_o && !pwrite_i && paddr_i == a;
    endsequence
    // Shadow of the bus-visible settings, bits 3 and 4 never enabled
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            mask_q <= MASK_RST;
            idle_q <= IDLE_RST;
            baud_q <= BAUD_RST;
            guard_q <= GUARD_RST;
        end else if (wr) begin
            if (paddr_i == IEN_OFS) mask_q <= mask_q | (pwdata_i[STAT_W-1:0] & 10'h3E7);
            if (paddr_i == IDIS_OFS) mask_q <= mask_q & ~pwdata_i[STAT_W-1:0];
            if (paddr_i == IDLE_OFS) idle_q <= pwdata_i[15:0];
            if (paddr_i == BAUD_OFS) baud_q <= pwdata_i[15:0];
            if (paddr_i == GUARD_OFS) guard_q <= pwdata_i[7:0];
        end
    end
    chk_mask_read: assert property (s_rd(IMASK_OFS) |-> prdata_o == {22'h0, mask_q})
        else $error("enable mask readback wrong");
    chk_irq_quiet: assert property (mask_q == 0 && $past(mask_q) == 0 |-> !irq_o)
        else $error("interrupt with all enables clear");
    chk_idle_irq: assert property ((mask_q[TXIDLE_BIT] && tx_shift_idle_i) [*3] |-> irq_o)
        else $error("no interrupt for enabled tx idle");
    chk_free_irq: assert property ((mask_q[TXFREE_BIT] && tx_holding_free_i) [*3] |-> irq_o)
        else $error("no interrupt for enabled tx free");
    chk_off_flag: assert property (s_rd(STAT_OFS) ##0 (idle_q == 0 && $past(idle_q) == 0)
        |-> !prdata_o[TIMEOUT_BIT])
        else $error("timeout flag with zero reload");
    chk_guard_start: assert property (tx_char_done_i && guard_q != 0 |=> ##[0:2] tx_guard_busy_o)
        else $error("timeguard did not start");
    chk_guard_zero: assert property (tx_char_done_i && guard_q == 0 && !tx_guard_busy_o |=> !tx_guard_busy_o)
        else $error("timeguard ran with zero length");
    chk_tick_gap: assert property (bit_tick_o && baud_q != 0 && $past(baud_q, 3) != 0 |=> !bit_tick_o)
        else $error("bit ticks too close");
endmodule
bind urt_receiver_timeout urt_receiver_timeout_asserts i_urt_receiver_timeout_asserts (
    .clk_i(clk_i), .nrst_i(nrst_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
    .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .tx_holding_free_i(tx_holding_free_i), .tx_shift_idle_i(tx_shift_idle_i), .tx_char_done_i(tx_char_done_i),
    .tx_guard_busy_o(tx_guard_busy_o), .bit_tick_o(bit_tick_o), .irq_o(irq_o));

/* File: urt_line_model.sv */
`timescale 1ns/1ps
module urt_line_model
    import urt_pkg::*;
(
    // Clock
    input wire logic clk_i,
    // Line side
    output logic rx_valid_o,
    output urt_rx_char_t rx_char_o,
    output logic break_o
);
    initial begin
        rx_valid_o = 1'b0;
        rx_char_o = '0;
        break_o = 1'b0;
    end
    // One-cycle offer per character; data lines scrambled between characters
    task automatic send(input urt_rx_char_t c);
        rx_valid_o <= 1'b1;
        rx_char_o <= c;
        @(posedge clk_i);
        rx_valid_o <= 1'b0;
        rx_char_o <= ~c;
        @(posedge clk_i);
    endtask
    task automatic brk;
        break_o <= 1'b1;
        @(posedge clk_i);
        break_o <= 1'b0;
        @(posedge clk_i);
    endtask
endmodule

/* File: urt_receiver_timeout_tb.sv */
`timescale 1ns/1ps
`define CHK(n, e, a) begin comparisons++; if ((a) !== (e)) begin mismatches++; $display("[FAIL] %s exp %h got %h", n, e, a); end end
module urt_receiver_timeout_tb;
    import urt_pkg::*;
    logic clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, done = 0, hfree = 0, sidle = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, rdat;
    logic rerr;
    wire [31:0] prdata;
    wire pready, pslverr, rx_holding_full, busy, tick, irq, rxv, brk;
    urt_rx_char_t rxc;
    int mismatches = 0, comparisons = 0;
    always #5 clk = ~clk;
    urt_line_model i_urt_line_model (.clk_i(clk), .rx_valid_o(rxv), .rx_char_o(rxc), .break_o(brk));
    urt_receiver_timeout #(.FIFO_DEPTH(4)) i_urt_receiver_timeout (
        .clk_i(clk), .nrst_i(nrst), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
        .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .rx_valid_i(rxv),
        .rx_char_i(rxc), .rx_ready_o(rx_holding_full), .break_detected_i(brk), .tx_holding_free_i(hfree),
        .tx_shift_idle_i(sidle), .tx_char_done_i(done), .tx_guard_busy_o(busy), .bit_tick_o(tick), .irq_o(irq));
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a);
        apb(1'b0, a, 32'h0);
    endtask
    task automatic expect_to(input int w, input logic v);
        repeat (w) @(posedge clk);
        rd(STAT_OFS);
        `CHK("timeout flag", v, rdat[TIMEOUT_BIT])
    endtask
    task automatic t_regs;
        rd(IDLE_OFS);
        `CHK("idle reset", 32'h0, rdat)
        wr(IDLE_OFS, 32'h0000FFFF);
        rd(IDLE_OFS);
        `CHK("idle width", 32'h0000FFFF, rdat)
        wr(IDLE_OFS, 32'h0);
        sidle <= 1;
        hfree <= 1;
        done <= 1;
        rd(STAT_OFS);
        done <= 0;
        `CHK("tx status", 2'b11, {rdat[TXIDLE_BIT], rdat[TXFREE_BIT]})
        wr(IEN_OFS, 32'h3FF);
        wr(IEN_OFS, 32'h0);
        rd(IMASK_OFS);
        `CHK("mask set", 32'h3E7, rdat)
        `CHK("irq on", 1'b1, irq)
        wr(IDIS_OFS, 32'h3FF);
        rd(IMASK_OFS);
        `CHK("mask clr", 32'h0, rdat)
        rd(8'h24);
        `CHK("unmapped", 33'h100000000, {rerr, rdat})
    endtask
    task automatic t_fifo;
        for (int i = 0; i < 5; i++) i_urt_line_model.send(urt_rx_char_t'({2'(i), 8'hA0 + 8'(i)}));
        i_urt_line_model.brk();
        rd(STAT_OFS);
        `CHK("rx flags", 10'h0E5, rdat[9:0] & 10'h0E5)
        `CHK("rx ready full", 1'b0, rx_holding_full)
        for (int i = 0; i < 4; i++) begin
            rd(RXDATA_OFS);
            `CHK("rx char", {2'(i), 8'hA0 + 8'(i)}, rdat[9:0])
        end
        wr(CMD_OFS, 32'h2);
        rd(STAT_OFS);
        `CHK("rx cleared", 10'h000, rdat[9:0] & 10'h1E5)
        `CHK("rx ready free", 1'b1, rx_holding_full)
    endtask
    task automatic t_guard;
        int n;
        wr(GUARD_OFS, 32'hFF);
        done <= 1;
        @(posedge clk);
        done <= 0;
        n = 0;
        while (busy !== 1'b1 && n < 10) begin
            @(posedge clk);
            n++;
        end
        n = 0;
        while (busy === 1'b1 && n < 400) begin
            @(posedge clk);
            n++;
        end
        `CHK("guard length", 1'b1, n >= 255 && n <= 257)
    endtask
    task automatic t_to;
        logic t0;
        sidle <= 0;
        hfree <= 0;
        expect_to(30, 1'b0);
        wr(IDLE_OFS, 32'd20);
        expect_to(5, 1'b0);
        expect_to(20, 1'b1);
        wr(IEN_OFS, 32'h100);
        repeat (3) @(posedge clk);
        `CHK("timeout irq", 1'b1, irq)
        wr(CMD_OFS, 32'h2);
        expect_to(40, 1'b0);
        i_urt_line_model.send(urt_rx_char_t'(10'h055));
        expect_to(5, 1'b0);
        expect_to(20, 1'b1);
        wr(CMD_OFS, 32'h1);
        expect_to(40, 1'b0);
        i_urt_line_model.send(urt_rx_char_t'(10'h0AA));
        expect_to(20, 1'b1);
        wr(BAUD_OFS, 32'h1);
        wr(CMD_OFS, 32'h2);
        i_urt_line_model.send(urt_rx_char_t'(10'h033));
        expect_to(25, 1'b0);
        expect_to(20, 1'b1);
        // Divider of one gives a tick on every second clock
        repeat (2) begin
            @(posedge clk);
            t0 = tick;
            @(posedge clk);
            `CHK("tick period", 1'b1, tick ^ t0)
        end
    endtask
    task automatic wrap_up;
        if (mismatches == 0 && comparisons > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        wrap_up();
    end
    initial begin
        repeat (20) @(posedge clk);
        nrst <= 1;
        @(posedge clk);
        t_regs();
        t_fifo();
        t_guard();
        t_to();
        wrap_up();
    end
endmodule
